// [prs_ctl_center.sv]
// control center model that issues each run request on both run paths
`timescale 1ns/100ps
`default_nettype none
module prs_ctl_center (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // run request and hardwired lag in cycles
    input wire logic run_req_in,
    input wire logic [7:0] hw_lag_in,
    // redundant run outputs
    output logic hardwired_run_input_out,
    output logic serial_run_out
);
    logic [7:0] lag_r;
    // serial follows the request, hardwired follows after the lag
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lag_r <= 8'h00;
            serial_run_out <= 1'b0;
            hardwired_run_input_out <= 1'b0;
        end else begin
            serial_run_out <= run_req_in;
            if (!run_req_in) begin
                lag_r <= 8'h00;
                hardwired_run_input_out <= 1'b0;
            end else if (lag_r >= hw_lag_in) begin
                hardwired_run_input_out <= 1'b1;
            end else begin
                lag_r <= lag_r + 8'h01;
            end
        end
    end
endmodule : prs_ctl_center
`default_nettype wire

// [prs_pkg.sv]
// types for the precharge and run supervisor
`default_nettype none
package prs_pkg;
    typedef enum logic [2:0] {
        PRS_IDLE,
        PRS_STAGE1,
        PRS_STAGE2,
        PRS_DONE,
        PRS_WAIT,
        PRS_LOCKOUT
    } prs_state_t;
endpackage : prs_pkg
`default_nettype wire

// [prs_regs.svh]
// constants for the precharge and run supervisor
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
`define PRS_CLK_HZ 32'd10000000
`define PRS_TICK_HZ 32'd10
`define PRS_TICK_DIV (`PRS_CLK_HZ / `PRS_TICK_HZ)
`define PRS_STAGE1_S 32'd4
`define PRS_STAGE2_S 32'd12
`define PRS_WAIT_S 32'd10
`define PRS_RUN_S 32'd5
`define PRS_STAGE1_TICKS (`PRS_STAGE1_S * `PRS_TICK_HZ)
`define PRS_STAGE2_TICKS (`PRS_STAGE2_S * `PRS_TICK_HZ)
`define PRS_WAIT_TICKS (`PRS_WAIT_S * `PRS_TICK_HZ)
`define PRS_RUN_TICKS (`PRS_RUN_S * `PRS_TICK_HZ)
`define PRS_THR1_LOW 10'h029
`define PRS_THR1_HIGH 10'h032
`define PRS_THR2_LOW 10'h1f4
`define PRS_THR2_HIGH 10'h1f4
`define PRS_FAULT_LIMIT 2'h3
`endif

// [prs_supervisor.sv]
// precharge timing, fault retry and redundant run supervision
// Function
// - stage one raises a low bus fault if the bus is not above its threshold within 4 s of the precharge command.
// - stage two raises its own low bus fault if the bus is not above its threshold within 12 s of the command.
// - the threshold follows the line voltage setting, 41 for 380/415 and 50 for 460 in stage one.
// - after a first or second precharge fault the block waits 10 s before clearing it and allowing another attempt.
// - fan and pump outputs stay on for the whole post-fault wait.
// - consecutive precharge faults are counted and the third one enters a lockout shutdown.
// - a 5 s supervision timer starts when the serial run command arrives without the hardwired run input.
// - if the hardwired run input has not arrived when the 5 s timer expires the block shuts down with a run fault.
// - a gate driver fault on any phase shuts the drive down and is reported for that phase.
`timescale 1ns/100ps
`default_nettype none
`include "prs_regs.svh"
module prs_supervisor
    import prs_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // precharge control
    input wire logic precharge_cmd_in,
    input wire logic line_sel_460_in,
    input wire logic [9:0] bus_volts_in,
    // run commands
    input wire logic hardwired_run_input_in,
    input wire logic serial_run_in,
    // gate driver monitors, one bit per phase
    input wire logic [2:0] gate_fault_in,
    // precharge status
    output logic precharge_ok_out,
    output logic low_bus1_fault_out,
    output logic low_bus2_fault_out,
    output logic lockout_out,
    output logic fan_pump_on_out,
    output logic [1:0] fault_count_out,
    // run and shutdown status
    output logic run_fault_out,
    output logic [2:0] gate_fault_out,
    output logic shutdown_out
);
    logic tick;
    prs_state_t state_r, state_nxt;
    logic [7:0] tcnt_r, tcnt_nxt;
    logic [1:0] fcnt_r, fcnt_nxt;
    logic f1_r, f1_nxt, f2_r, f2_nxt;
    logic s1_ok_r, s1_ok_nxt;
    logic run_tmr_on_r, run_tmr_on_nxt;
    logic [7:0] run_cnt_r, run_cnt_nxt;
    logic run_fault_r, run_fault_nxt;
    logic [2:0] gate_r, gate_nxt;

    // bus threshold for a stage from the line voltage setting
    function automatic logic [9:0] prs_threshold(input logic stage2, input logic sel460);
        if (stage2)
            prs_threshold = sel460 ? `PRS_THR2_HIGH : `PRS_THR2_LOW;
        else
            prs_threshold = sel460 ? `PRS_THR1_HIGH : `PRS_THR1_LOW;
    endfunction : prs_threshold

    // slow time base
    prs_tick_gen u_tick (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_out(tick)
    );

    // precharge sequence, fault wait and lockout
    always_comb begin
        state_nxt = state_r;
        tcnt_nxt = tcnt_r;
        fcnt_nxt = fcnt_r;
        f1_nxt = f1_r;
        f2_nxt = f2_r;
        s1_ok_nxt = s1_ok_r;
        if (tick && tcnt_r != 8'hff)
            tcnt_nxt = tcnt_r + 8'h1;
        case (state_r)
            PRS_IDLE: begin
                if (precharge_cmd_in) begin
                    state_nxt = PRS_STAGE1;
                    tcnt_nxt = 8'h0;
                    s1_ok_nxt = 1'b0;
                end
            end
            PRS_STAGE1, PRS_STAGE2: begin
                // stage one passes once, stage two must follow within 12 s of the command
                if (state_r == PRS_STAGE1 && bus_volts_in > prs_threshold(1'b0, line_sel_460_in)) begin
                    s1_ok_nxt = 1'b1;
                    state_nxt = PRS_STAGE2;
                end
                if (state_r == PRS_STAGE2 && bus_volts_in > prs_threshold(1'b1, line_sel_460_in)) begin
                    state_nxt = PRS_DONE;
                    fcnt_nxt = 2'h0;
                end else if (state_r == PRS_STAGE1 && !(bus_volts_in > prs_threshold(1'b0, line_sel_460_in))
                             && tcnt_r >= 8'(`PRS_STAGE1_TICKS)) begin
                    f1_nxt = 1'b1;
                end else if (state_r == PRS_STAGE2 && tcnt_r >= 8'(`PRS_STAGE2_TICKS)) begin
                    f2_nxt = 1'b1;
                end
                if (f1_nxt != f1_r || f2_nxt != f2_r) begin
                    fcnt_nxt = fcnt_r + 2'h1;
                    tcnt_nxt = 8'h0;
                    state_nxt = (fcnt_r + 2'h1 == `PRS_FAULT_LIMIT) ? PRS_LOCKOUT : PRS_WAIT;
                end
                if (!precharge_cmd_in && state_nxt != PRS_WAIT && state_nxt != PRS_LOCKOUT)
                    state_nxt = PRS_IDLE;
            end
            PRS_DONE: begin
                if (!precharge_cmd_in)
                    state_nxt = PRS_IDLE;
            end
            PRS_WAIT: begin
                if (tcnt_r >= 8'(`PRS_WAIT_TICKS)) begin
                    state_nxt = PRS_IDLE;
                    f1_nxt = 1'b0;
                    f2_nxt = 1'b0;
                end
            end
            PRS_LOCKOUT: begin
                state_nxt = PRS_LOCKOUT;
            end
            default: state_nxt = PRS_IDLE;
        endcase
    end

    // register precharge state
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= PRS_IDLE;
            tcnt_r <= 8'h0;
            fcnt_r <= 2'h0;
            f1_r <= 1'b0;
            f2_r <= 1'b0;
            s1_ok_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tcnt_r <= tcnt_nxt;
            fcnt_r <= fcnt_nxt;
            f1_r <= f1_nxt;
            f2_r <= f2_nxt;
            s1_ok_r <= s1_ok_nxt;
        end
    end

    // run supervision timer and gate driver capture
    always_comb begin
        run_tmr_on_nxt = run_tmr_on_r;
        run_cnt_nxt = run_cnt_r;
        run_fault_nxt = run_fault_r;
        gate_nxt = gate_r | gate_fault_in;
        if (!hardwired_run_input_in && !serial_run_in) begin
            // request withdrawn, stop supervising so no stale timeout follows
            run_tmr_on_nxt = 1'b0;
        end else if (!run_tmr_on_r && !hardwired_run_input_in && !run_fault_r) begin
            // a hardwired command already present satisfies the check at once, so no restart loop
            run_tmr_on_nxt = 1'b1;
            run_cnt_nxt = 8'h0;
        end else if (run_tmr_on_r) begin
            if (hardwired_run_input_in) begin
                run_tmr_on_nxt = 1'b0;
            end else if (run_cnt_r >= 8'(`PRS_RUN_TICKS)) begin
                run_fault_nxt = 1'b1;
                run_tmr_on_nxt = 1'b0;
            end else if (tick) begin
                run_cnt_nxt = run_cnt_r + 8'h1;
            end
        end
        if (!hardwired_run_input_in && !serial_run_in && run_fault_r)
            run_fault_nxt = 1'b0;
        if (!hardwired_run_input_in && !serial_run_in && !run_tmr_on_r)
            gate_nxt = gate_fault_in;
    end

    // register run supervision state
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_tmr_on_r <= 1'b0;
            run_cnt_r <= 8'h0;
            run_fault_r <= 1'b0;
            gate_r <= 3'h0;
        end else begin
            run_tmr_on_r <= run_tmr_on_nxt;
            run_cnt_r <= run_cnt_nxt;
            run_fault_r <= run_fault_nxt;
            gate_r <= gate_nxt;
        end
    end

    // status outputs
    assign precharge_ok_out = (state_r == PRS_DONE);
    assign low_bus1_fault_out = f1_r;
    assign low_bus2_fault_out = f2_r;
    assign lockout_out = (state_r == PRS_LOCKOUT);
    assign fan_pump_on_out = (state_r == PRS_WAIT);
    assign fault_count_out = fcnt_r;
    assign run_fault_out = run_fault_r;
    assign gate_fault_out = gate_r;
    assign shutdown_out = f1_r | f2_r | lockout_out | run_fault_r | (|gate_r);

    // checks
    chk_wait_fans: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state_r == PRS_WAIT) |-> fan_pump_on_out && (f1_r || f2_r))
        else $error("fan and pump off during fault wait");
    chk_lockout_third: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(state_r == PRS_LOCKOUT) |-> fcnt_r == `PRS_FAULT_LIMIT)
        else $error("lockout without three faults");
    chk_stage1_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(f1_r) |-> $past(tcnt_r) >= 8'(`PRS_STAGE1_TICKS))
        else $error("stage one fault too early");
    chk_stage2_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(f2_r) |-> $past(tcnt_r) >= 8'(`PRS_STAGE2_TICKS) && $past(s1_ok_r))
        else $error("stage two fault too early");
    chk_stage1_pass: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_r == PRS_STAGE1 && precharge_cmd_in
        && bus_volts_in > (line_sel_460_in ? `PRS_THR1_HIGH : `PRS_THR1_LOW) |=> state_r == PRS_STAGE2)
        else $error("stage one not passed above its threshold");
    chk_stage1_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_r == PRS_STAGE1
        && bus_volts_in <= (line_sel_460_in ? `PRS_THR1_HIGH : `PRS_THR1_LOW) |=> state_r != PRS_STAGE2)
        else $error("stage one passed at or below its threshold");
    chk_wait_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(state_r == PRS_WAIT) |-> $past(tcnt_r) >= 8'(`PRS_WAIT_TICKS) && !f1_r && !f2_r)
        else $error("fault wait ended early");
    chk_count_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(state_r == PRS_DONE) |-> fcnt_r == 2'h0)
        else $error("fault count not cleared on success");
    chk_run_fault: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(run_fault_r) |-> $past(run_cnt_r) >= 8'(`PRS_RUN_TICKS) && !$past(hardwired_run_input_in))
        else $error("run fault without timeout");
    chk_run_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(run_tmr_on_r) |-> run_cnt_r == 8'h0 && $past(hardwired_run_input_in || serial_run_in))
        else $error("run timer started without command");
    chk_gate_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (|gate_fault_in) |=> shutdown_out && ((gate_r & $past(gate_fault_in)) == $past(gate_fault_in)))
        else $error("gate fault not reported");
endmodule : prs_supervisor
`default_nettype wire

// [prs_supervisor_tb_top.sv]
// self-checking bench for the precharge and run supervisor
`timescale 1ns/100ps
`default_nettype none
module prs_supervisor_tb_top;
    logic clk_in, reset_n_in, cmd, sel, run_req, hw_run, ser_run, ok, lb1, lb2, lock, fan, rf, sd, seen;
    logic [9:0] bus;
    logic [2:0] gf_in, gf_out;
    logic [1:0] fcnt;
    logic [7:0] lag;
    integer seed, miscompares, n_compared, i, k;
    // design and control center model
    prs_supervisor i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .precharge_cmd_in(cmd),
        .line_sel_460_in(sel), .bus_volts_in(bus), .hardwired_run_input_in(hw_run), .serial_run_in(ser_run),
        .gate_fault_in(gf_in), .precharge_ok_out(ok), .low_bus1_fault_out(lb1), .low_bus2_fault_out(lb2),
        .lockout_out(lock), .fan_pump_on_out(fan), .fault_count_out(fcnt), .run_fault_out(rf),
        .gate_fault_out(gf_out), .shutdown_out(sd));
    prs_ctl_center i_ctl (.clk_in(clk_in), .reset_n_in(reset_n_in), .run_req_in(run_req), .hw_lag_in(lag),
        .hardwired_run_input_out(hw_run), .serial_run_out(ser_run));
    // 100 ns clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // precharge completes only once the bus is strictly above the stage two level
    function automatic logic exp_done(input logic [9:0] v);
        return v > 10'h1f4;
    endfunction : exp_done
    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit
    task automatic check_vec(input string name, input logic [2:0] exp, input logic [2:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check_vec
    task automatic cycles(input integer n);
        repeat (n) @(negedge clk_in);
    endtask : cycles
    // no precharge fault, lockout or fan may appear this early
    task automatic check_quiet();
        check_bit("low_bus1", 1'b0, lb1);
        check_bit("low_bus2", 1'b0, lb2);
        check_bit("lockout", 1'b0, lock);
        check_bit("fan_pump", 1'b0, fan);
        check_vec("fault_count", 3'h0, {1'b0, fcnt});
    endtask : check_quiet
    task automatic conclude();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        seed = 63;
        miscompares = 0;
        n_compared = 0;
        reset_n_in = 1'b0;
        cmd = 1'b0;
        sel = 1'b0;
        bus = 10'h000;
        run_req = 1'b0;
        lag = 8'h00;
        gf_in = 3'h0;
        cycles(10);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        cycles(1);
        check_quiet();
        check_bit("shutdown", 1'b0, sd);
        $display("test reset done");
        // precharge against stage thresholds, with corner values first
        for (i = 0; i < 12; i++) begin
            @(posedge clk_in);
            sel <= i[0];
            case (i)
                0: bus <= 10'h1f4;
                1: bus <= 10'h1f5;
                2: bus <= 10'h029;
                3: bus <= 10'h033;
                4: bus <= 10'h02a;
                5: bus <= 10'h032;
                default: bus <= 10'($random(seed));
            endcase
            cmd <= 1'b1;
            seen = 1'b0;
            for (k = 0; k < 8; k++) begin
                cycles(1);
                seen = seen | ok;
            end
            check_bit("precharge_ok", exp_done(bus), seen);
            check_quiet();
            @(posedge clk_in);
            cmd <= 1'b0;
            cycles(3);
            check_bit("precharge_ok_drop", 1'b0, ok);
            check_quiet();
        end
        $display("test precharge done");
        // redundant run with hardwired lag well inside the supervision time
        for (i = 0; i < 4; i++) begin
            @(posedge clk_in);
            lag <= (i == 0) ? 8'h00 : 8'($random(seed));
            run_req <= 1'b1;
            cycles(270);
            check_bit("run_fault", 1'b0, rf);
            check_bit("shutdown_run", 1'b0, sd);
            // gate fault on one phase while running
            @(posedge clk_in);
            gf_in <= 3'h1 << (i % 3);
            @(posedge clk_in);
            gf_in <= 3'h0;
            cycles(2);
            check_vec("gate_fault", 3'h1 << (i % 3), gf_out);
            check_bit("shutdown_gate", 1'b1, sd);
            @(posedge clk_in);
            run_req <= 1'b0;
            cycles(6);
            check_vec("gate_fault_clear", 3'h0, gf_out);
            check_bit("shutdown_clear", 1'b0, sd);
        end
        $display("test run and gate done");
        conclude();
    end
    // cut a hang short
    initial begin
        #8000000;
        miscompares = miscompares + 1;
        conclude();
    end
endmodule : prs_supervisor_tb_top
`default_nettype wire

// [prs_tick_gen.sv]
// slow tick divider for the precharge and run supervisor
`timescale 1ns/100ps
`default_nettype none
`include "prs_regs.svh"
module prs_tick_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // tick output
    output logic tick_out
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // divide the clock down to a 100 ms tick
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r == `PRS_TICK_DIV - 32'h1) begin
            cnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end
    end

    // register divider state
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule : prs_tick_gen
`default_nettype wire
